// [include/tx_line_consts.svh]
// Offsets, field positions, reset values and rate figures of the line output stage
`ifndef TX_LINE_CONSTS_SVH
`define TX_LINE_CONSTS_SVH

// Register byte addresses
`define TXL_CTRL_ADDR         4'h0
`define TXL_STATUS_ADDR       4'h4

// Control field positions
`define TXL_CTRL_RAILSEL_BIT  0
`define TXL_CTRL_DIGMODE_BIT  1
`define TXL_CTRL_TRISTATE_BIT 2
`define TXL_CTRL_FULLBAUD_BIT 3
`define TXL_CTRL_POL_BIT      4
`define TXL_CTRL_CMI_BIT      5
`define TXL_CTRL_RLOOP_BIT    6
`define TXL_CTRL_T1_BIT       7

// Control reset value: tristate bit set, everything else clear
`define TXL_CTRL_RESET        8'h04

// Status field positions
`define TXL_STAT_ANALOG_BIT   0
`define TXL_STAT_DUAL_BIT     1
`define TXL_STAT_OPTICAL_BIT  2
`define TXL_STAT_T1_BIT       3
`define TXL_STAT_MARKVALID_BIT 4

// Line rates in kbit/s
`define TXL_E1_RATE_KBPS      2048
`define TXL_T1_RATE_KBPS      1544

// AXI response codes
`define TXL_RESP_OKAY         2'h0
`define TXL_RESP_SLVERR       2'h2

`endif

// [include/tx_line_pkg.sv]
// Types of the transmit line output stage
package tx_line_pkg;

  // Software control bits of one port
  typedef struct packed {
    logic t1Mode;
    logic remoteLoop;
    logic cmiCode;
    logic outputPolaritySelect;
    logic fullBaudSelect;
    logic txLineTristate;
    logic txDigitalMode;
    logic digitalRailSelect;
  } ctrl_t;

  // Output form chosen by the control bits
  typedef enum logic [1:0] {
    MODE_ANALOG  = 2'b00,
    MODE_DUAL    = 2'b01,
    MODE_OPTICAL = 2'b10
  } out_mode_t;

  // Coded symbols from the transmit coder, on the line clock
  typedef struct packed {
    logic symPos;
    logic symNeg;
    logic optBit;
    logic frameStart;
  } tx_sym_t;

  // One driven pin: level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } pin_t;

endpackage

// [logic/tx_line_output_formatter.sv]
// Transmit line output stage of one port: register slave, mode select and line drivers
`timescale 1ns/1ps
`include "tx_line_consts.svh"

// What this block does
// - Rail select clear routes data to analog
// - Analog tristate until mode bit set, tristate cleared
// - Rail select and mode bit select dual-rail
// - Rail select, mode bit clear: optical
// - Rail pulse half or full bit
// - Rails updated on line clock rising edge
// - Polarity bit; reset value gives active-low rails
// - Polarity bit; reset value gives active-high optical
// - NRZ optical: full bit, rising edge
// - CMI optical uses both clock edges
// - Digital tristate until rail select set, tristate cleared
// - Optical only: marker on first frame bit
// - Marker not valid in remote loop
// - Optical rate E1 or T1/J1
module tx_line_output_formatter (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // AXI4-Lite slave
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Link side
  input  wire logic                 txLineClk,
  input  wire tx_line_pkg::tx_sym_t txSym,
  output tx_line_pkg::pin_t         analogLineOutA,
  output tx_line_pkg::pin_t         analogLineOutB,
  output tx_line_pkg::pin_t         positiveRailOut,
  output tx_line_pkg::pin_t         negativeRailOut,
  output tx_line_pkg::pin_t         opticalDataOut,
  output tx_line_pkg::pin_t         txFrameMarker
);

  // System-domain state
  typedef struct packed {
    // Write address and data, kept until both are in
    logic                awHeld;
    logic [3:0]          awAddr;
    logic                wHeld;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    // Answers waiting for the master
    logic                bValid;
    logic [1:0]          bResp;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
    // Software control bits
    tx_line_pkg::ctrl_t  ctrl;
    // Enables brought back from the line clock
    logic [2:0]          statSync1;
    logic [2:0]          statSync2;
  } sys_state_t;

  // Line-clock rising-edge state
  typedef struct packed {
    // Reset and control brought over from the system clock
    logic                rstSync1;
    logic                rstSync2;
    tx_line_pkg::ctrl_t  cfgSync1;
    tx_line_pkg::ctrl_t  cfgSync2;
    // Bit phase and registered line bits
    logic                phase;
    logic                posBit;
    logic                negBit;
    logic                optBit;
    logic                cmiLevel;
    logic                markBit;
    // Enables for the status read-back
    logic [2:0]          enables;
  } link_state_t;

  // Line-clock falling-edge state
  typedef struct packed {
    logic                phaseCopy;
  } fall_state_t;

  sys_state_t             sys_r;
  sys_state_t             sys_nxt;
  link_state_t            link_r;
  link_state_t            link_nxt;
  fall_state_t            fall_r;
  fall_state_t            fall_nxt;

  logic                   awFire;
  logic                   wFire;
  logic                   arFire;
  logic                   doWrite;
  logic [31:0]            statusWord;
  logic                   linkRst;
  tx_line_pkg::ctrl_t     cfg;
  tx_line_pkg::out_mode_t mode;
  logic                   analogOn;
  logic                   digitalOn;
  logic                   dualOn;
  logic                   opticalOn;
  logic                   firstHalf;
  logic                   railPos;
  logic                   railNeg;
  logic                   optLine;
  logic                   ctrlWrHit;
  logic                   statWrHit;
  logic                   ctrlRdHit;
  logic                   statRdHit;

  // Bus handshakes
  assign s_axi_awready = ~sys_r.awHeld & ~sys_r.bValid;
  assign s_axi_wready  = ~sys_r.wHeld & ~sys_r.bValid;
  assign s_axi_arready = ~sys_r.rValid;
  assign awFire        = s_axi_awvalid & s_axi_awready;
  assign wFire         = s_axi_wvalid & s_axi_wready;
  assign arFire        = s_axi_arvalid & s_axi_arready;
  assign doWrite       = sys_r.awHeld & sys_r.wHeld & ~sys_r.bValid;

  // Bus answers from flip-flops
  assign s_axi_bvalid = sys_r.bValid;
  assign s_axi_bresp  = sys_r.bResp;
  assign s_axi_rvalid = sys_r.rValid;
  assign s_axi_rdata  = sys_r.rData;
  assign s_axi_rresp  = sys_r.rResp;

  // Word address decode for writes and reads
  assign ctrlWrHit = (sys_r.awAddr[3:2] == 2'(`TXL_CTRL_ADDR >> 2));
  assign statWrHit = (sys_r.awAddr[3:2] == 2'(`TXL_STATUS_ADDR >> 2));
  assign ctrlRdHit = (s_axi_araddr[3:2] == 2'(`TXL_CTRL_ADDR >> 2));
  assign statRdHit = (s_axi_araddr[3:2] == 2'(`TXL_STATUS_ADDR >> 2));

  // Status word from synchronised link enables and the control bits
  // Enable bits lag the control write by a few cycles
  // Each bit is a level, so no bundling is needed
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`TXL_STAT_ANALOG_BIT]    = sys_r.statSync2[0];
    statusWord[`TXL_STAT_DUAL_BIT]      = sys_r.statSync2[1];
    statusWord[`TXL_STAT_OPTICAL_BIT]   = sys_r.statSync2[2];
    statusWord[`TXL_STAT_T1_BIT]        = sys_r.ctrl.t1Mode;
    statusWord[`TXL_STAT_MARKVALID_BIT] = ~sys_r.ctrl.remoteLoop;
  end

  // System-domain next state: register slave
  always_comb begin
    sys_nxt = sys_r;
    sys_nxt.statSync1 = link_r.enables;
    sys_nxt.statSync2 = sys_r.statSync1;
    if (awFire) begin
      sys_nxt.awHeld = 1'b1;
      sys_nxt.awAddr = s_axi_awaddr;
    end
    if (wFire) begin
      sys_nxt.wHeld = 1'b1;
      sys_nxt.wData = s_axi_wdata;
      sys_nxt.wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      sys_nxt.awHeld = 1'b0;
      sys_nxt.wHeld  = 1'b0;
      sys_nxt.bValid = 1'b1;
      if (ctrlWrHit) begin
        sys_nxt.bResp = `TXL_RESP_OKAY;
        if (sys_r.wStrb[0]) begin
          sys_nxt.ctrl = tx_line_pkg::ctrl_t'(sys_r.wData[7:0]);
        end
      end else if (statWrHit) begin
        sys_nxt.bResp = `TXL_RESP_OKAY;
      end else begin
        sys_nxt.bResp = `TXL_RESP_SLVERR;
      end
    end
    if (sys_r.bValid && s_axi_bready) begin
      sys_nxt.bValid = 1'b0;
    end
    if (sys_r.rValid && s_axi_rready) begin
      sys_nxt.rValid = 1'b0;
    end
    if (arFire) begin
      sys_nxt.rValid = 1'b1;
      sys_nxt.rResp  = `TXL_RESP_OKAY;
      if (ctrlRdHit) begin
        sys_nxt.rData = {24'h00_0000, sys_r.ctrl};
      end else if (statRdHit) begin
        sys_nxt.rData = statusWord;
      end else begin
        sys_nxt.rData = 32'h0000_0000;
        sys_nxt.rResp = `TXL_RESP_SLVERR;
      end
    end
  end

  // System-domain registers
  // Reset leaves the tristate bit set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sys_r           <= '0;
      sys_r.ctrl      <= tx_line_pkg::ctrl_t'(`TXL_CTRL_RESET);
    end else begin
      sys_r           <= sys_nxt;
    end
  end

  // Link-domain view of control and reset
  // Control is quasi-static: software waits before relying on it
  // A change may take two or three line clocks to apply
  // Reset reaches the line side through two flip-flops
  assign linkRst = link_r.rstSync2;
  assign cfg     = link_r.cfgSync2;

  // Mode decode from the two select bits
  // Unused code falls back to analog
  always_comb begin
    case ({cfg.digitalRailSelect, cfg.txDigitalMode})
      2'b11:   mode = tx_line_pkg::MODE_DUAL;
      2'b10:   mode = tx_line_pkg::MODE_OPTICAL;
      default: mode = tx_line_pkg::MODE_ANALOG;
    endcase
  end

  // Output enables per form
  // Levels of the current bits, never latched
  // Synced reset forces every pin to high impedance
  assign analogOn  = ~linkRst & (mode == tx_line_pkg::MODE_ANALOG)
                   & cfg.txDigitalMode & ~cfg.txLineTristate;
  assign digitalOn = ~linkRst & cfg.digitalRailSelect & ~cfg.txLineTristate;
  assign dualOn    = digitalOn & (mode == tx_line_pkg::MODE_DUAL);
  assign opticalOn = digitalOn & (mode == tx_line_pkg::MODE_OPTICAL);

  // Link-domain next state
  always_comb begin
    link_nxt          = link_r;
    link_nxt.rstSync1 = srst;
    link_nxt.rstSync2 = link_r.rstSync1;
    link_nxt.cfgSync1 = sys_r.ctrl;
    link_nxt.cfgSync2 = link_r.cfgSync1;
    link_nxt.enables  = {opticalOn, dualOn, analogOn};
    if (linkRst) begin
      link_nxt.phase    = 1'b0;
      link_nxt.posBit   = 1'b0;
      link_nxt.negBit   = 1'b0;
      link_nxt.optBit   = 1'b0;
      link_nxt.cmiLevel = 1'b0;
      link_nxt.markBit  = 1'b0;
      link_nxt.enables  = 3'h0;
    end else begin
      link_nxt.phase  = ~link_r.phase;
      link_nxt.posBit = txSym.symPos;
      link_nxt.negBit = txSym.symNeg;
      link_nxt.optBit = txSym.optBit;
      if (txSym.optBit) begin
        link_nxt.cmiLevel = ~link_r.cmiLevel;
      end
      link_nxt.markBit = txSym.frameStart & (mode == tx_line_pkg::MODE_OPTICAL);
    end
  end

  // Link-domain rising-edge registers
  always_ff @(posedge txLineClk) begin
    link_r <= link_nxt;
  end

  // Falling-edge copy of the bit phase
  // Only the phase crosses to the falling edge
  always_comb begin
    fall_nxt           = fall_r;
    fall_nxt.phaseCopy = link_r.phase;
  end

  // Falling-edge register
  always_ff @(negedge txLineClk) begin
    fall_r <= fall_nxt;
  end

  // High in the first half of each bit period
  // Phase differs from its copy until the falling edge
  // Gives half-bit timing without a faster clock
  assign firstHalf = link_r.phase ^ fall_r.phaseCopy;

  // Rail pulse width and polarity
  // Half baud cuts the pulse at the falling edge
  // Polarity bit clear gives active-low rails
  always_comb begin
    if (cfg.fullBaudSelect) begin
      railPos = link_r.posBit;
      railNeg = link_r.negBit;
    end else begin
      railPos = link_r.posBit & firstHalf;
      railNeg = link_r.negBit & firstHalf;
    end
    railPos = railPos ^ ~cfg.outputPolaritySelect;
    railNeg = railNeg ^ ~cfg.outputPolaritySelect;
  end

  // Optical level: NRZ or CMI, then polarity
  // CMI zero: low then high; CMI one: alternating level
  // Polarity bit clear gives active-high data
  always_comb begin
    if (cfg.cmiCode) begin
      optLine = link_r.optBit ? link_r.cmiLevel : ~firstHalf;
    end else begin
      optLine = link_r.optBit;
    end
    optLine = optLine ^ cfg.outputPolaritySelect;
  end

  // Analog driver, first line
  assign analogLineOutA.level  = link_r.posBit;
  assign analogLineOutA.oe     = analogOn;

  // Analog driver, second line
  assign analogLineOutB.level  = link_r.negBit;
  assign analogLineOutB.oe     = analogOn;

  // Positive rail
  assign positiveRailOut.level = railPos;
  assign positiveRailOut.oe    = dualOn;

  // Negative rail
  assign negativeRailOut.level = railNeg;
  assign negativeRailOut.oe    = dualOn;

  // Optical data, rate set by the line clock
  assign opticalDataOut.level  = optLine;
  assign opticalDataOut.oe     = opticalOn;

  // Frame marker, never inverted
  assign txFrameMarker.level   = link_r.markBit;
  assign txFrameMarker.oe      = opticalOn;

endmodule

// [sim/tx_line_output_formatter_props.sv]
// Port checker of the transmit line output stage
`timescale 1ns/1ps
module tx_line_output_formatter_props (
  input wire logic                 clk_sys,
  input wire logic                 srst,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 txLineClk,
  input wire tx_line_pkg::tx_sym_t txSym,
  input wire tx_line_pkg::pin_t    analogLineOutA,
  input wire tx_line_pkg::pin_t    positiveRailOut,
  input wire tx_line_pkg::pin_t    negativeRailOut,
  input wire tx_line_pkg::pin_t    opticalDataOut
);
  // Register bus answers
  a_write_answer: assert property (@(posedge clk_sys) disable iff (srst)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_bresp_hold: assert property (@(posedge clk_sys) disable iff (srst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (srst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_read_answer: assert property (@(posedge clk_sys) disable iff (srst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_busy: assert property (@(posedge clk_sys) disable iff (srst)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // Line pins
  a_analog_data: assert property (@(posedge txLineClk) disable iff (srst)
    analogLineOutA.oe && $past(analogLineOutA.oe) |-> analogLineOutA.level == $past(txSym.symPos))
    else $error("analog level wrong");
  a_modes_exclusive: assert property (@(posedge txLineClk) disable iff (srst)
    !(analogLineOutA.oe && (positiveRailOut.oe || opticalDataOut.oe)))
    else $error("analog and digital both driven");
  a_rail_pair: assert property (@(posedge txLineClk) disable iff (srst)
    positiveRailOut.oe == negativeRailOut.oe)
    else $error("rails enabled apart");
endmodule

bind tx_line_output_formatter tx_line_output_formatter_props i_tx_line_output_formatter_props (.*);

// [sim/line_receiver.sv]
// Far-end receiver model: samples all line pins twice per bit
`timescale 1ns/1ps
module line_receiver (
  input wire logic        txLineClk,
  input wire logic [11:0] pinBus,
  output logic [11:0]     early,
  output logic [11:0]     late,
  output logic            tick = 1'b0
);
  // First half after the rising edge, second half after the falling edge
  always @(posedge txLineClk) begin
    #3 early = pinBus;
    #8 late = pinBus;
    tick = ~tick;
  end
endmodule

// [sim/tx_line_output_formatter_test.sv]
// Self-checking bench of the transmit line output stage
`timescale 1ns/1ps
`include "tx_line_consts.svh"
module tx_line_output_formatter_test;
  logic               clk_sys = 1'b0;
  logic               txLineClk = 1'b0;
  logic               srst = 1'b1;
  logic [3:0]         s_axi_awaddr = 4'h0;
  logic [3:0]         s_axi_araddr = 4'h0;
  logic [3:0]         s_axi_wstrb = 4'hf;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [31:0]        s_axi_rdata;
  tx_line_pkg::tx_sym_t txSym = 4'h0;
  tx_line_pkg::pin_t  analogLineOutA, analogLineOutB, positiveRailOut;
  tx_line_pkg::pin_t  negativeRailOut, opticalDataOut, txFrameMarker;
  logic [11:0]        early, late;
  logic               rxTick;
  tx_line_pkg::ctrl_t cfg = 8'h04;
  logic [33:0]        axiQ [$];
  logic [11:0]        lineQ [$];
  int                 fails = 0;
  int                 check_count = 0;
  logic [7:0]         cfgs [10] = '{8'h02, 8'h06, 8'h03, 8'h13, 8'h1b, 8'h81, 8'h11, 8'h21,
                                    8'h41, 8'h05};

  tx_line_output_formatter i_tx_line_output_formatter (.*);
  line_receiver i_line_receiver (
    .txLineClk(txLineClk),
    .pinBus({analogLineOutA, analogLineOutB, positiveRailOut, negativeRailOut,
             opticalDataOut, txFrameMarker}),
    .early(early),
    .late(late),
    .tick(rxTick)
  );

  // Clocks: system 8 ns, line 15 ns
  always #4 clk_sys = ~clk_sys;
  always #7.5 txLineClk = ~txLineClk;

  // Enabled output form: {optical, dual, analog}
  function automatic logic [2:0] modes(tx_line_pkg::ctrl_t c);
    logic on;
    on = !c.txLineTristate;
    modes = {c.digitalRailSelect & !c.txDigitalMode & on,
             c.digitalRailSelect & c.txDigitalMode & on,
             !c.digitalRailSelect & c.txDigitalMode & on};
  endfunction

  // Pin levels and enables in one bit half
  function automatic logic [11:0] expect_pins(logic [11:0] n, logic h);
    tx_line_pkg::ctrl_t c;
    tx_line_pkg::tx_sym_t s;
    logic p;
    logic [2:0] md;
    {c, s} = n;
    p = c.outputPolaritySelect;
    md = modes(c);
    expect_pins = {s.symPos, md[0], s.symNeg, md[0],
                   ~((s.symPos & (c.fullBaudSelect | !h)) ^ p), md[1],
                   ~((s.symNeg & (c.fullBaudSelect | !h)) ^ p), md[1],
                   (c.cmiCode ? h : s.optBit) ^ p, md[2], s.frameStart, md[2]};
  endfunction

  // Line result against expectation
  task automatic cmp_line(logic [11:0] n);
    tx_line_pkg::ctrl_t c;
    logic [2:0] md;
    logic [11:0] m;
    logic [23:0] e;
    c = n[11:4];
    md = modes(c);
    m = {md[0], 1'b1, md[0], 1'b1, md[1], 1'b1, md[1], 1'b1,
         md[2] & !(c.cmiCode & n[1]), 1'b1, md[2] & !c.remoteLoop,
         1'b1};
    e = {expect_pins(n, 1'b0), expect_pins(n, 1'b1)} & {m, m};
    check_count++;
    if (({early, late} & {m, m}) !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {early, late} & {m, m}, e);
    end
  endtask

  // Register answer against expectation
  task automatic cmp_axi(logic [33:0] got);
    logic [33:0] e;
    e = axiQ.pop_front();
    check_count++;
    if (got !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One bus access; answer ready raised after a random delay
  task automatic axi_op(logic wr, logic [3:0] a, logic [31:0] d, logic [33:0] e);
    logic aw, w, b;
    int dly;
    aw = 1'b1;
    w = wr;
    b = 1'b1;
    dly = $urandom % 4;
    axiQ.push_back(e);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    for (int t = 0; t < 64 && b; t++) begin
      @(posedge clk_sys);
      aw = aw & !(wr ? s_axi_awready : s_axi_arready);
      w = w & !s_axi_wready;
      b = b & !((wr ? s_axi_bvalid : s_axi_rvalid) & (t > dly));
      s_axi_awvalid <= aw & wr;
      s_axi_arvalid <= aw & !wr;
      s_axi_wvalid <= w;
      s_axi_bready <= b & wr & (t >= dly);
      s_axi_rready <= b & !wr & (t >= dly);
    end
    if (b) begin
      fails++;
      test_done();
    end
  endtask

  // Random symbols; each noted when the stage samples it
  task automatic send_syms(int n);
    logic [3:0] prev;
    prev = txSym;
    for (int i = 0; i <= n; i++) begin
      @(posedge txLineClk);
      if (i > 0) lineQ.push_back({cfg, prev});
      prev = 4'($urandom);
      txSym <= prev;
    end
  endtask

  // Result watchers
  always @(posedge clk_sys)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
      cmp_axi(s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata});
  always @(rxTick)
    if (lineQ.size() > 0) cmp_line(lineQ.pop_front());

  // Main sequence
  initial begin
    void'($urandom(37));
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    axi_op(1'b0, `TXL_CTRL_ADDR, 32'h0, {2'h0, 32'h04});
    axi_op(1'b0, `TXL_STATUS_ADDR, 32'h0, {2'h0, 32'h10});
    axi_op(1'b1, 4'h8, 32'h1, {`TXL_RESP_SLVERR, 32'h0});
    axi_op(1'b0, 4'hc, 32'h0, {`TXL_RESP_SLVERR, 32'h0});
    axi_op(1'b1, `TXL_STATUS_ADDR, 32'hff, 34'h0);
    send_syms(8);
    foreach (cfgs[i]) begin
      cfg = cfgs[i];
      axi_op(1'b1, `TXL_CTRL_ADDR, {24'h0, cfgs[i]}, 34'h0);
      axi_op(1'b0, `TXL_CTRL_ADDR, 32'h0, {2'h0, 24'h0, cfgs[i]});
      repeat (6) @(posedge txLineClk);
      axi_op(1'b0, `TXL_STATUS_ADDR, 32'h0, {29'h0, cfg.t1Mode, modes(cfg)} |
             {2'h0, 27'h0, !cfg.remoteLoop, 4'h0});
      send_syms(24);
    end
    repeat (4) @(posedge txLineClk);
    test_done();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule
